// file: hdl/acb_pkg.sv
package acb_pkg;

    // Clock and timing figures, in nanoseconds as specified.
    localparam int CLK_PERIOD_NS = 40;
    localparam int STS_RISE_MAX_NS = 600;
    localparam int STS_HOLD_MIN_NS = 300;
    localparam int STS_HOLD_MAX_NS = 1000;
    localparam int CONV12_MAX_NS = 35000;
    localparam int CONV8_MAX_NS = 24000;

    // Least times round up, longest times round down.
    localparam int STS_RISE_CYC = STS_RISE_MAX_NS / CLK_PERIOD_NS;
    localparam int STS_HOLD_CYC = (STS_HOLD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STS_HOLD_MAX_CYC = STS_HOLD_MAX_NS / CLK_PERIOD_NS;
    localparam int CONV12_CYC = CONV12_MAX_NS / CLK_PERIOD_NS;
    localparam int CONV8_CYC = CONV8_MAX_NS / CLK_PERIOD_NS;
    localparam int COUNT_W = 10;

    // Result layout.
    localparam int RESULT_W = 12;
    localparam int RESULT_BIT_MSB = 11;
    localparam int RESULT_BIT_LSB = 0;
    localparam int BYTE_LO_BIT = 4;
    localparam int NIBBLE_HI_BIT = 3;

    // Control pins, in the order carried through the synchroniser.
    localparam int PIN_W = 5;
    localparam int PIN_CE = 0;
    localparam int PIN_CS_N = 1;
    localparam int PIN_RC = 2;
    localparam int PIN_WIDE = 3;
    localparam int PIN_BYTE = 4;
    localparam logic [PIN_W-1:0] PIN_RST = 5'h02;

    // APB register map.
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] REG_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] REG_STAT = 12'h004;
    localparam logic [ADDR_W-1:0] REG_RESULT = 12'h008;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_SHORT_BIT = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_SHORT_BIT = 1;
    localparam int STAT_OE_BIT = 2;
    localparam int STAT_PIN_LO = 8;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01,
        ST_HOLD = 2'b10
    } acb_state_t;

endpackage

// file: hdl/acb_pin_if.sv
`timescale 1ns/1ns
interface acb_pin_if #(
    parameter int WIDTH = acb_pkg::PIN_W
);
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] filt;

    modport sync (input raw, output filt);
    modport user (output raw, input filt);
endinterface

// file: hdl/acb_pin_sync.sv
`timescale 1ns/1ns
module acb_pin_sync #(
    parameter int WIDTH = acb_pkg::PIN_W,
    parameter logic [WIDTH-1:0] RST_VAL = acb_pkg::PIN_RST
) (
    input wire logic pclk, // Bus clock.
    input wire logic presetn, // Asynchronous reset, active low.
    acb_pin_if.sync pins // Raw pins in, filtered levels out.
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync2_ff;
    logic [WIDTH-1:0] sync3_ff;
    logic [WIDTH-1:0] filt_ff;
    logic [WIDTH-1:0] nxt_filt;

    // A level counts only once the second and third stage agree, so a
    // glitch caught by the first stage never reaches the control logic.
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            nxt_filt[i] = (sync2_ff[i] == sync3_ff[i]) ? sync3_ff[i] : filt_ff[i];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= RST_VAL;
            sync2_ff <= RST_VAL;
            sync3_ff <= RST_VAL;
            filt_ff <= RST_VAL;
        end else begin
            meta_ff <= pins.raw;
            sync2_ff <= meta_ff;
            sync3_ff <= sync2_ff;
            filt_ff <= nxt_filt;
        end
    end

    assign pins.filt = filt_ff;
endmodule // acb_pin_sync

// file: hdl/acb_conv_ctrl.sv
// The address map and register access over APB were left to the implementer.
`timescale 1ns/1ns
module acb_conv_ctrl #(
    parameter int CONV12_CYCLES = acb_pkg::CONV12_CYC,
    parameter int CONV8_CYCLES = acb_pkg::CONV8_CYC
) (
    input wire logic pclk, // APB clock, 25 MHz.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB access phase.
    input wire logic pwrite, // APB direction, high for write.
    input wire logic [acb_pkg::ADDR_W-1:0] paddr, // APB byte address.
    input wire logic [acb_pkg::DATA_W-1:0] pwdata, // APB write data.
    output logic [acb_pkg::DATA_W-1:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error for unmapped addresses.
    input wire logic chip_enable, // Chip enable pin, active high.
    input wire logic chip_select_n, // Chip select pin, active low.
    input wire logic read_convert, // High reads, falling edge converts.
    input wire logic bus_width_sel, // High for 12-bit word, low for bytes.
    input wire logic byte_address, // Byte select and short-cycle select.
    input wire logic [acb_pkg::RESULT_W-1:0] analog_code, // Digitised input value.
    output logic [acb_pkg::RESULT_W-1:0] result_bus_o, // Result data lines.
    output logic result_bus_oe, // High while result lines are driven.
    output logic conversion_status // High while a conversion is under way.
);
    localparam int RISE_BOUND = acb_pkg::STS_RISE_CYC;
    localparam int HOLD_MAX = acb_pkg::STS_HOLD_MAX_CYC;

    acb_pin_if #(.WIDTH(acb_pkg::PIN_W)) pin_bus ();

    acb_pin_sync #(
        .WIDTH(acb_pkg::PIN_W),
        .RST_VAL(acb_pkg::PIN_RST)
    ) u_pin_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pins(pin_bus.sync)
    );

    always_comb begin
        pin_bus.raw = '0;
        pin_bus.raw[acb_pkg::PIN_CE] = chip_enable;
        pin_bus.raw[acb_pkg::PIN_CS_N] = chip_select_n;
        pin_bus.raw[acb_pkg::PIN_RC] = read_convert;
        pin_bus.raw[acb_pkg::PIN_WIDE] = bus_width_sel;
        pin_bus.raw[acb_pkg::PIN_BYTE] = byte_address;
    end

    logic ce_f;
    logic cs_n_f;
    logic rc_f;
    logic wide_f;
    logic byte_f;
    logic read_cond;
    logic start_cond;
    logic pin_start;
    logic soft_start;
    logic start_take;
    logic apb_acc;
    logic apb_hit;

    assign ce_f = pin_bus.filt[acb_pkg::PIN_CE];
    assign cs_n_f = pin_bus.filt[acb_pkg::PIN_CS_N];
    assign rc_f = pin_bus.filt[acb_pkg::PIN_RC];
    assign wide_f = pin_bus.filt[acb_pkg::PIN_WIDE];
    assign byte_f = pin_bus.filt[acb_pkg::PIN_BYTE];

    // In stand-alone wiring enable and select are fixed, so these reduce to
    // read/convert high and read/convert low.
    assign read_cond = ce_f && !cs_n_f && rc_f;
    assign start_cond = ce_f && !cs_n_f && !rc_f;

    acb_pkg::acb_state_t state_ff;
    acb_pkg::acb_state_t nxt_state;
    logic [acb_pkg::COUNT_W-1:0] cnt_ff;
    logic [acb_pkg::COUNT_W-1:0] nxt_cnt;
    logic [acb_pkg::RESULT_W-1:0] sample_ff;
    logic [acb_pkg::RESULT_W-1:0] nxt_sample;
    logic [acb_pkg::RESULT_W-1:0] result_ff;
    logic [acb_pkg::RESULT_W-1:0] nxt_result;
    logic short_ff;
    logic nxt_short;
    logic status_ff;
    logic nxt_status;
    logic start_cond_ff;
    logic soft_short_ff;
    logic nxt_soft_short;

    // A start is an edge into the convert condition, so a level held low
    // does not retrigger after the cycle ends.
    assign pin_start = start_cond && !start_cond_ff;
    assign apb_acc = psel && penable && pready;
    assign apb_hit = (paddr == acb_pkg::REG_CTRL) || (paddr == acb_pkg::REG_STAT)
        || (paddr == acb_pkg::REG_RESULT);
    assign soft_start = apb_acc && pwrite && (paddr == acb_pkg::REG_CTRL)
        && pwdata[acb_pkg::CTRL_START_BIT];
    assign start_take = (state_ff == acb_pkg::ST_IDLE) && (pin_start || soft_start);

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_sample = sample_ff;
        nxt_result = result_ff;
        nxt_short = short_ff;
        nxt_status = status_ff;
        case (state_ff)
            acb_pkg::ST_IDLE: begin
                if (start_take) begin
                    nxt_state = acb_pkg::ST_CONV;
                    nxt_short = pin_start ? byte_f
                        : pwdata[acb_pkg::CTRL_SHORT_BIT];
                    nxt_cnt = nxt_short ? acb_pkg::COUNT_W'(CONV8_CYCLES - 1)
                        : acb_pkg::COUNT_W'(CONV12_CYCLES - 1);
                    nxt_sample = analog_code;
                    nxt_status = 1'b1;
                end
            end
            acb_pkg::ST_CONV: begin
                // Further starts are not looked at outside the idle state.
                if (cnt_ff == '0) begin
                    nxt_state = acb_pkg::ST_HOLD;
                    nxt_cnt = acb_pkg::COUNT_W'(acb_pkg::STS_HOLD_CYC - 1);
                    nxt_result = sample_ff;
                    if (short_ff) begin
                        nxt_result[acb_pkg::NIBBLE_HI_BIT:acb_pkg::RESULT_BIT_LSB] = '0;
                    end
                end else begin
                    nxt_cnt = cnt_ff - 1'b1;
                end
            end
            acb_pkg::ST_HOLD: begin
                // Result is valid here; status stays up for the minimum hold.
                if (cnt_ff == '0) begin
                    nxt_state = acb_pkg::ST_IDLE;
                    nxt_status = 1'b0;
                end else begin
                    nxt_cnt = cnt_ff - 1'b1;
                end
            end
            default: begin
                nxt_state = acb_pkg::ST_IDLE;
                nxt_status = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= acb_pkg::ST_IDLE;
            cnt_ff <= '0;
            sample_ff <= '0;
            result_ff <= '0;
            short_ff <= 1'b0;
            status_ff <= 1'b0;
            start_cond_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            sample_ff <= nxt_sample;
            result_ff <= nxt_result;
            short_ff <= nxt_short;
            status_ff <= nxt_status;
            start_cond_ff <= start_cond;
        end
    end

    logic [acb_pkg::RESULT_W-1:0] bus_ff;
    logic [acb_pkg::RESULT_W-1:0] nxt_bus;
    logic oe_ff;
    logic nxt_oe;

    // Drivers come on only when idle and reading; a start in the same cycle
    // wins so the lines never drive into a conversion.
    always_comb begin
        nxt_oe = (state_ff == acb_pkg::ST_IDLE) && read_cond && !start_take;
        nxt_bus = '0;
        if (wide_f) begin
            nxt_bus = result_ff;
        end else if (!byte_f) begin
            nxt_bus[acb_pkg::RESULT_BIT_MSB:acb_pkg::BYTE_LO_BIT] =
                result_ff[acb_pkg::RESULT_BIT_MSB:acb_pkg::BYTE_LO_BIT];
        end else begin
            nxt_bus[acb_pkg::RESULT_BIT_MSB:acb_pkg::BYTE_LO_BIT] =
                {result_ff[acb_pkg::NIBBLE_HI_BIT:acb_pkg::RESULT_BIT_LSB], 4'h0};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_ff <= '0;
            oe_ff <= 1'b0;
        end else begin
            bus_ff <= nxt_bus;
            oe_ff <= nxt_oe;
        end
    end

    assign result_bus_o = bus_ff;
    assign result_bus_oe = oe_ff;
    assign conversion_status = status_ff;

    logic [acb_pkg::DATA_W-1:0] rdata_ff;
    logic [acb_pkg::DATA_W-1:0] nxt_rdata;
    logic ready_ff;
    logic nxt_ready;
    logic err_ff;
    logic nxt_err;

    // One wait state: ready rises in the second access cycle, with data.
    always_comb begin
        nxt_ready = psel && penable && !ready_ff;
        nxt_err = nxt_ready && !apb_hit;
        nxt_rdata = '0;
        nxt_soft_short = soft_short_ff;
        if (nxt_ready && !pwrite) begin
            case (paddr)
                acb_pkg::REG_CTRL: nxt_rdata[acb_pkg::CTRL_SHORT_BIT] = soft_short_ff;
                acb_pkg::REG_STAT: begin
                    nxt_rdata[acb_pkg::STAT_BUSY_BIT] = status_ff;
                    nxt_rdata[acb_pkg::STAT_SHORT_BIT] = short_ff;
                    nxt_rdata[acb_pkg::STAT_OE_BIT] = oe_ff;
                    nxt_rdata[acb_pkg::STAT_PIN_LO +: acb_pkg::PIN_W] = pin_bus.filt;
                end
                acb_pkg::REG_RESULT: nxt_rdata[acb_pkg::RESULT_W-1:0] = result_ff;
                default: nxt_rdata = '0;
            endcase
        end
        if (apb_acc && pwrite && (paddr == acb_pkg::REG_CTRL)) begin
            nxt_soft_short = pwdata[acb_pkg::CTRL_SHORT_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_ff <= '0;
            ready_ff <= 1'b0;
            err_ff <= 1'b0;
            soft_short_ff <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            ready_ff <= nxt_ready;
            err_ff <= nxt_err;
            soft_short_ff <= nxt_soft_short;
        end
    end

    assign prdata = rdata_ff;
    assign pready = ready_ff;
    assign pslverr = err_ff;

    a_status_rise: assert property (
        @(posedge pclk) disable iff (!presetn)
        (state_ff == acb_pkg::ST_IDLE && !status_ff && $fell(read_convert)
            && chip_enable && !chip_select_n && $stable(chip_enable) && $stable(chip_select_n))
        |-> ##[1:RISE_BOUND] conversion_status)
        else $error("status did not rise after read/convert fell");

    a_status_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(state_ff == acb_pkg::ST_HOLD) |-> conversion_status [*8] ##1 !conversion_status)
        else $error("status fall not 300 ns after result");

    a_status_fall_max: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(state_ff == acb_pkg::ST_HOLD) |-> ##[1:HOLD_MAX] !conversion_status)
        else $error("status fall later than 1000 ns");

    a_busy_float: assert property (
        @(posedge pclk) disable iff (!presetn)
        conversion_status |-> !result_bus_oe)
        else $error("result lines driven during conversion");

    a_busy_ignore: assert property (
        @(posedge pclk) disable iff (!presetn)
        (status_ff && (pin_start || soft_start) && state_ff == acb_pkg::ST_CONV)
        |=> $stable(sample_ff) && $stable(short_ff))
        else $error("start accepted while busy");

    a_read_drive: assert property (
        @(posedge pclk) disable iff (!presetn)
        (state_ff == acb_pkg::ST_IDLE && read_cond && !start_take) |=> result_bus_oe)
        else $error("result lines not driven on read");

    a_fall_float: assert property (
        @(posedge pclk) disable iff (!presetn)
        !read_cond |=> !result_bus_oe)
        else $error("result lines not floated after read/convert fell");

    a_start_edge: assert property (
        @(posedge pclk) disable iff (!presetn)
        ($rose(start_cond) && state_ff == acb_pkg::ST_IDLE)
        |=> state_ff == acb_pkg::ST_CONV && status_ff)
        else $error("falling read/convert did not start a conversion");

    a_word_format: assert property (
        @(posedge pclk) disable iff (!presetn)
        (result_bus_oe && $past(wide_f)) |-> result_bus_o == result_ff)
        else $error("12-bit word not presented");

    a_byte_format: assert property (
        @(posedge pclk) disable iff (!presetn)
        (result_bus_oe && !$past(wide_f) && $past(byte_f))
        |-> result_bus_o == {result_ff[3:0], 8'h00})
        else $error("low byte not left-justified");

    a_short_select: assert property (
        @(posedge pclk) disable iff (!presetn)
        (state_ff == acb_pkg::ST_IDLE && pin_start)
        |=> short_ff == $past(byte_f) ##1 1'b1)
        else $error("conversion length not taken from byte address");
endmodule // acb_conv_ctrl

// file: verification/acb_host_model.sv
`timescale 1ns/1ns
// Host glue logic that drives the converter's control pins, with enable held high and select low except while set_mode moves the mode pins.
module acb_host_model (
    input wire logic pclk, // Bus clock.
    output logic chip_enable, // Held high.
    output logic chip_select_n, // Held low, except while set_mode moves the mode pins.
    output logic read_convert, // Toggled by set_rc to read and convert.
    output logic bus_width_sel, // Word or byte mode.
    output logic byte_address, // Byte select, set high for the low byte and for short cycles.
    input wire logic conversion_status, // Busy flag from the converter.
    input wire logic [11:0] result_bus_o, // Result lines from the converter.
    input wire logic result_bus_oe // High while the result lines are driven.
);
    logic sts_d1 = 1'b0;
    logic sts_d2 = 1'b0;
    logic [11:0] latched = 12'h000;

    // External latch: the lines come up a cycle after status falls, so the
    // capture waits two edges past the fall.
    always @(posedge pclk) begin
        sts_d1 <= conversion_status;
        sts_d2 <= sts_d1;
        if (sts_d2 && !sts_d1 && result_bus_oe) begin
            latched <= result_bus_o;
        end
    end

    initial begin
        chip_enable = 1'b1;
        chip_select_n = 1'b0;
        read_convert = 1'b1;
        bus_width_sel = 1'b1;
        byte_address = 1'b0;
    end

    // Chip select closes the read while the mode pins move, so no read sees them change.
    task automatic set_mode(input logic wide, input logic sel);
        @(posedge pclk);
        chip_select_n <= 1'b1;
        repeat (6) @(posedge pclk);
        bus_width_sel <= wide;
        byte_address <= sel;
        repeat (6) @(posedge pclk);
        chip_select_n <= 1'b0;
    endtask

    task automatic set_rc(input logic lvl, input int hold);
        @(posedge pclk);
        read_convert <= lvl;
        repeat (hold) @(posedge pclk);
    endtask

    // The host reads only once status has dropped, as polling would show.
    task automatic wait_done(output int n);
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (conversion_status !== 1'b0 && n < 400);
    endtask
endmodule // acb_host_model

// file: verification/tb_top.sv
`timescale 1ns/1ns
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_count++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module tb_top;
    localparam int C12 = 20;
    localparam int C8 = 10;
    localparam int HOLD = 8;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr, analog_code, result_bus_o;
    logic [31:0] pwdata, prdata, rd;
    logic chip_enable, chip_select_n, read_convert, bus_width_sel, byte_address;
    logic result_bus_oe, conversion_status, err;
    int err_count = 0;
    int num_checks = 0;
    int n;

    acb_conv_ctrl #(.CONV12_CYCLES(C12), .CONV8_CYCLES(C8)) acb_conv_ctrl_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .chip_enable(chip_enable), .chip_select_n(chip_select_n),
        .read_convert(read_convert), .bus_width_sel(bus_width_sel),
        .byte_address(byte_address), .analog_code(analog_code),
        .result_bus_o(result_bus_o), .result_bus_oe(result_bus_oe),
        .conversion_status(conversion_status));
    acb_host_model acb_host_model_i (.pclk(pclk), .chip_enable(chip_enable),
        .chip_select_n(chip_select_n), .read_convert(read_convert),
        .bus_width_sel(bus_width_sel), .byte_address(byte_address),
        .conversion_status(conversion_status), .result_bus_o(result_bus_o),
        .result_bus_oe(result_bus_oe));

    always #20 pclk = ~pclk;

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Counts negative edges until status reaches the given level.
    task automatic wait_sts(input logic lvl, output int k);
        k = 0;
        do begin
            @(negedge pclk);
            k++;
        end while (conversion_status !== lvl && k < 400);
        `CHK(conversion_status, lvl)
    endtask

    task automatic t_reset();
        @(negedge pclk);
        `CHK({conversion_status, result_bus_oe}, 2'b00)
        repeat (10) @(posedge pclk);
        apb(1'b0, acb_pkg::REG_STAT, 32'h0);
        `CHK(rd, 32'h00000D04)
        apb(1'b0, acb_pkg::REG_RESULT, 32'h0);
        `CHK(rd, 32'h00000000)
        apb(1'b0, 12'h00C, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        apb(1'b1, 12'h010, 32'h3);
        `CHK({err, conversion_status}, 2'b10)
    endtask

    // Low pulse with a second, ignored fall while busy.
    task automatic t_low();
        analog_code <= 12'hABC;
        acb_host_model_i.set_rc(1'b0, 0);
        wait_sts(1'b1, n);
        `CHK(n <= 15, 1'b1)
        `CHK(result_bus_oe, 1'b0)
        acb_host_model_i.set_rc(1'b1, 4);
        acb_host_model_i.set_rc(1'b0, 4);
        acb_host_model_i.set_rc(1'b1, 0);
        `CHK(result_bus_oe, 1'b0)
        wait_sts(1'b0, n);
        `CHK(n + 15 >= C12 + HOLD && n <= C12 + HOLD, 1'b1)
        repeat (3) @(negedge pclk);
        `CHK({result_bus_oe, result_bus_o}, {1'b1, 12'hABC})
        `CHK(acb_host_model_i.latched, 12'hABC)
        repeat (10) @(negedge pclk);
        `CHK(conversion_status, 1'b0)
    endtask

    task automatic t_byte();
        analog_code <= 12'h5A7;
        acb_host_model_i.set_mode(1'b0, 1'b0);
        acb_host_model_i.set_rc(1'b0, 5);
        acb_host_model_i.set_rc(1'b1, 0);
        acb_host_model_i.wait_done(n);
        `CHK(conversion_status, 1'b0)
        repeat (6) @(negedge pclk);
        `CHK({result_bus_oe, result_bus_o}, {1'b1, 12'h5A0})
        acb_host_model_i.set_mode(1'b0, 1'b1);
        repeat (6) @(negedge pclk);
        `CHK(result_bus_o, 12'h700)
    endtask

    task automatic t_short();
        analog_code <= 12'hFFF;
        acb_host_model_i.set_mode(1'b1, 1'b1);
        repeat (6) @(posedge pclk);
        acb_host_model_i.set_rc(1'b0, 5);
        acb_host_model_i.set_rc(1'b1, 0);
        wait_sts(1'b0, n);
        `CHK(n <= C8 + HOLD, 1'b1)
        acb_host_model_i.set_mode(1'b1, 1'b0);
        apb(1'b0, acb_pkg::REG_RESULT, 32'h0);
        `CHK(rd, 32'h00000FF0)
    endtask

    // High pulse: lines float from the fall until rc is high again.
    task automatic t_high();
        analog_code <= 12'h3C5;
        repeat (6) @(negedge pclk);
        `CHK(result_bus_oe, 1'b1)
        acb_host_model_i.set_rc(1'b0, 6);
        `CHK({conversion_status, result_bus_oe}, 2'b10)
        wait_sts(1'b0, n);
        repeat (10) @(negedge pclk);
        `CHK(result_bus_oe, 1'b0)
        acb_host_model_i.set_rc(1'b1, 6);
        `CHK({result_bus_oe, result_bus_o}, {1'b1, 12'h3C5})
    endtask

    task automatic t_soft();
        analog_code <= 12'h123;
        apb(1'b1, acb_pkg::REG_CTRL, 32'h1);
        `CHK(err, 1'b0)
        repeat (8) @(posedge pclk);
        apb(1'b0, acb_pkg::REG_STAT, 32'h0);
        `CHK({rd[2], rd[0]}, 2'b01)
        wait_sts(1'b0, n);
        apb(1'b0, acb_pkg::REG_RESULT, 32'h0);
        `CHK(rd, 32'h00000123)
        analog_code <= 12'h9E7;
        apb(1'b1, acb_pkg::REG_CTRL, 32'h3);
        wait_sts(1'b0, n);
        `CHK(n < C12, 1'b1)
        apb(1'b0, acb_pkg::REG_CTRL, 32'h0);
        `CHK(rd, 32'h00000002)
        apb(1'b0, acb_pkg::REG_STAT, 32'h0);
        `CHK(rd[2:0], 3'b110)
        apb(1'b0, acb_pkg::REG_RESULT, 32'h0);
        `CHK(rd, 32'h000009E0)
    endtask

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        analog_code = 12'h000;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_low();
        t_byte();
        t_short();
        t_high();
        t_soft();
        tally_and_finish();
    end

    // The scenarios need well under a thousand cycles.
    initial begin
        #(40 * 5000);
        err_count++;
        tally_and_finish();
    end
endmodule // tb_top
